// [rtl/aic_top.sv]
// analog input conditioning: registers, tick, filters, scaling, role select
module aic_top #(
  parameter int TICK_CYCLES = aic_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  input  wire logic [11:0] analogInPrimary,
  input  wire logic [11:0] analogInSecondary,
  input  wire logic        inputKindSwitch,
  output logic      [15:0] primaryOut,
  output logic      [15:0] secondaryOut,
  output logic      [15:0] gainScaleFactor,
  output logic             outStrobe,
  output logic      [4:0]  secondaryRole,
  output logic             secondaryRoleActive
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic        liveZero_q;
  logic [4:0]  func_q;
  logic [7:0]  tc_q   [2];
  logic [15:0] gain_q [2];
  logic [15:0] bias_q [2];
  logic [15:0] rdData_q;
  logic [1:0]  swSync_q;
  logic [TICK_CNT_W_L-1:0] tickCnt_q;
  logic        tick_q;
  logic        strobeDly_q;
  logic        outStrobe_q;
  logic [15:0] out_q  [2];
  logic [15:0] effGain_q;

  localparam int TICK_CNT_W_L = aic_pkg::TICK_CNT_W;

  wire wrCtrl = regWr && (regAddr == aic_pkg::REG_CTRL);
  wire [4:0] wrFunc = regWrData[aic_pkg::CTRL_FUNC_LSB +: 5];
  wire funcOk = wrFunc <= aic_pkg::FUNC_MAX;
  wire [7:0] wrTc = (regWrData[15:8] != 8'h00 || regWrData[7:0] > aic_pkg::TC_MAX) ?
                    aic_pkg::TC_MAX : regWrData[7:0];
  wire [15:0] wrGain = (regWrData > aic_pkg::GAIN_MAX) ? aic_pkg::GAIN_MAX : regWrData;
  wire signed [15:0] wrS = $signed(regWrData);
  wire [15:0] wrBias = (wrS > $signed(aic_pkg::BIAS_MAX)) ? aic_pkg::BIAS_MAX :
                       (wrS < $signed(aic_pkg::BIAS_MIN)) ? aic_pkg::BIAS_MIN : regWrData;

  wire [3:0] offTc   [2] = '{aic_pkg::REG_PRI_TC, aic_pkg::REG_SEC_TC};
  wire [3:0] offGain [2] = '{aic_pkg::REG_PRI_GAIN, aic_pkg::REG_SEC_GAIN};
  wire [3:0] offBias [2] = '{aic_pkg::REG_PRI_BIAS, aic_pkg::REG_SEC_BIAS};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      liveZero_q <= 1'b0;
      func_q     <= aic_pkg::RST_FUNC;
    end else if (wrCtrl) begin
      liveZero_q <= regWrData[aic_pkg::CTRL_LIVE_BIT];
      if (funcOk) begin
        func_q <= wrFunc;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel settings, filter and scaling
  // ----------------------------------------------------------------
  logic [11:0] rawCh    [2];
  logic [11:0] filtCh   [2];
  logic [11:0] fracCh   [2];
  logic [15:0] gainUse  [2];
  logic [15:0] scaledCh [2];

  assign rawCh[0] = analogInPrimary;
  assign rawCh[1] = analogInSecondary;

  wire [11:0] liveAdj  = (filtCh[1] > aic_pkg::LIVE_ZERO) ? filtCh[1] - aic_pkg::LIVE_ZERO :
                         12'h000;
  wire [12:0] liveSpan = {1'b0, liveAdj} + {3'b000, liveAdj[11:2]};
  assign fracCh[0] = filtCh[0];
  assign fracCh[1] = !liveZero_q ? filtCh[1] :
                     (liveSpan[12] ? aic_pkg::ADC_FULL : liveSpan[11:0]);

  // primary gain scaled by secondary percentage
  wire [15:0] secPos   = out_q[1][15] ? 16'h0000 : out_q[1];
  wire [31:0] gainMul  = gain_q[0] * secPos;
  wire [42:0] gainDiv  = gainMul * aic_pkg::PCT_DIV_MUL;
  wire [22:0] gainPct  = gainDiv[42:aic_pkg::PCT_DIV_SH];
  wire [15:0] gainEff  = (gainPct > {7'h00, aic_pkg::GAIN_MAX}) ? aic_pkg::GAIN_MAX :
                         gainPct[15:0];
  wire        useFgain = func_q == aic_pkg::FUNC_FREQ_GAIN;
  assign gainUse[0] = useFgain ? gainEff : gain_q[0];
  assign gainUse[1] = gain_q[1];

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    wire wrTcCh   = regWr && (regAddr == offTc[ch]);
    wire wrGainCh = regWr && (regAddr == offGain[ch]);
    wire wrBiasCh = regWr && (regAddr == offBias[ch]);

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        tc_q[ch]   <= aic_pkg::RST_TC;
        gain_q[ch] <= aic_pkg::RST_GAIN;
        bias_q[ch] <= aic_pkg::RST_BIAS;
      end else begin
        if (wrTcCh) begin
          tc_q[ch] <= wrTc;
        end
        if (wrGainCh) begin
          gain_q[ch] <= wrGain;
        end
        if (wrBiasCh) begin
          bias_q[ch] <= wrBias;
        end
      end
    end

    aic_filter u_filter (
      .clk       (clk),
      .rst_n     (rst_n),
      .tick      (tick_q),
      .timeConst (tc_q[ch]),
      .sampleIn  (rawCh[ch]),
      .filtered  (filtCh[ch])
    );

    wire signed [16:0] span = $signed({1'b0, gainUse[ch]}) - $signed({bias_q[ch][15], bias_q[ch]});
    wire signed [29:0] prod = span * $signed({1'b0, fracCh[ch]});
    wire signed [29:0] part = prod >>> aic_pkg::ADC_W;
    wire signed [17:0] sum  = $signed({{2{bias_q[ch][15]}}, bias_q[ch]}) + part[17:0];
    assign scaledCh[ch] = sum[15:0];

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        out_q[ch] <= 16'h0000;
      end else if (strobeDly_q) begin
        out_q[ch] <= scaledCh[ch];
      end
    end
  end

  // ----------------------------------------------------------------
  // sample tick, pin sync, output strobe
  // ----------------------------------------------------------------
  wire tickWrap = tickCnt_q == TICK_CNT_W_L'(TICK_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tickCnt_q   <= '0;
      tick_q      <= 1'b0;
      strobeDly_q <= 1'b0;
      outStrobe_q <= 1'b0;
      swSync_q    <= 2'b00;
      effGain_q   <= aic_pkg::RST_GAIN;
    end else begin
      tickCnt_q   <= tickWrap ? '0 : tickCnt_q + 1'b1;
      tick_q      <= tickWrap;
      strobeDly_q <= tick_q;
      outStrobe_q <= strobeDly_q;
      swSync_q    <= {swSync_q[0], inputKindSwitch};
      effGain_q   <= gainUse[0];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // reserved codes carry no role
  wire roleActive = (func_q != aic_pkg::FUNC_RSV_A) && (func_q != aic_pkg::FUNC_RSV_B);
  wire [15:0] ctrlRd = {3'b000, func_q, 7'h00, liveZero_q};
  wire [15:0] statRd = {14'h0000, roleActive, swSync_q[1]};
  wire [15:0] rdMux  =
      (regAddr == aic_pkg::REG_CTRL)     ? ctrlRd :
      (regAddr == aic_pkg::REG_PRI_TC)   ? {8'h00, tc_q[0]} :
      (regAddr == aic_pkg::REG_PRI_GAIN) ? gain_q[0] :
      (regAddr == aic_pkg::REG_PRI_BIAS) ? bias_q[0] :
      (regAddr == aic_pkg::REG_SEC_TC)   ? {8'h00, tc_q[1]} :
      (regAddr == aic_pkg::REG_SEC_GAIN) ? gain_q[1] :
      (regAddr == aic_pkg::REG_SEC_BIAS) ? bias_q[1] :
      (regAddr == aic_pkg::REG_STATUS)   ? statRd :
      (regAddr == aic_pkg::REG_PRI_OUT)  ? out_q[0] :
      (regAddr == aic_pkg::REG_SEC_OUT)  ? out_q[1] :
      (regAddr == aic_pkg::REG_EFF_GAIN) ? effGain_q : 16'h0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_q <= 16'h0000;
    end else begin
      rdData_q <= regRd ? rdMux : 16'h0000;
    end
  end

  assign regRdData           = rdData_q;
  assign primaryOut          = out_q[0];
  assign secondaryOut        = out_q[1];
  assign gainScaleFactor     = effGain_q;
  assign outStrobe           = outStrobe_q;
  assign secondaryRole       = func_q;
  assign secondaryRoleActive = roleActive;

endmodule // aic_top

// [rtl/aic_pkg.sv]
// constants, register map and types for the analog input conditioning block
// What this block does
// - type selector 0: secondary input spans zero to full scale.
// - type selector 1: secondary input has live zero, 20 percent of full scale.
// - gain sets output level in percent at full-scale input.
// - bias sets output level in percent at zero-point input.
// - each channel maps linearly between its own bias and gain points.
// - each channel has its own first-order low-pass, own time constant.
// - time constants 0.00 to 2.00 s in hundredths are accepted.
// - step response reaches 63 percent after one time constant.
// - function selector codes 0 to 17; codes 15 and 17 do nothing.
// - frequency-gain role: primary gain times conditioned secondary value.
package aic_pkg;

  // ----------------------------------------------------------------
  // widths and scaling
  // ----------------------------------------------------------------
  localparam int          ADC_W      = 12;
  localparam int          DATA_W     = 16;
  localparam int          ADDR_W     = 4;
  localparam int          ACC_W      = 28;
  localparam int          FRAC_W     = 16;
  localparam logic [11:0] ADC_FULL   = 12'hFFF;
  localparam logic [11:0] LIVE_ZERO  = 12'h333;
  localparam logic [16:0] ALPHA_ONE  = 17'h10000;
  localparam logic [7:0]  TC_MAX     = 8'hC8;
  localparam logic [15:0] GAIN_MAX   = 16'h2710;
  localparam logic [15:0] BIAS_MAX   = 16'h03E8;
  localparam logic [15:0] BIAS_MIN   = 16'hFC18;
  localparam logic [10:0] PCT_DIV_MUL = 11'h419;
  localparam int          PCT_DIV_SH = 20;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 20000000;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_CNT_W  = 18;

  // ----------------------------------------------------------------
  // secondary function codes
  // ----------------------------------------------------------------
  localparam logic [4:0] FUNC_FREQ_GAIN = 5'h01;
  localparam logic [4:0] FUNC_RSV_A     = 5'h0F;
  localparam logic [4:0] FUNC_RSV_B     = 5'h11;
  localparam logic [4:0] FUNC_MAX       = 5'h11;

  // ----------------------------------------------------------------
  // register offsets, fields, reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_PRI_TC   = 4'h1;
  localparam logic [3:0] REG_PRI_GAIN = 4'h2;
  localparam logic [3:0] REG_PRI_BIAS = 4'h3;
  localparam logic [3:0] REG_SEC_TC   = 4'h4;
  localparam logic [3:0] REG_SEC_GAIN = 4'h5;
  localparam logic [3:0] REG_SEC_BIAS = 4'h6;
  localparam logic [3:0] REG_STATUS   = 4'h7;
  localparam logic [3:0] REG_PRI_OUT  = 4'h8;
  localparam logic [3:0] REG_SEC_OUT  = 4'h9;
  localparam logic [3:0] REG_EFF_GAIN = 4'hA;

  localparam int CTRL_LIVE_BIT = 0;
  localparam int CTRL_FUNC_LSB = 8;
  localparam int STAT_SW_BIT   = 0;
  localparam int STAT_ROLE_BIT = 1;

  localparam logic [7:0]  RST_TC   = 8'h00;
  localparam logic [15:0] RST_GAIN = 16'h03E8;
  localparam logic [15:0] RST_BIAS = 16'h0000;
  localparam logic [4:0]  RST_FUNC = 5'h00;

  typedef enum logic [2:0] {
    DIV_IDLE = 3'b001,
    DIV_RUN  = 3'b010,
    DIV_DONE = 3'b100
  } aic_div_state_type;

endpackage

// [rtl/aic_filter.sv]
// one channel of first-order recursive low-pass with coefficient divider
module aic_filter (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic [7:0]  timeConst,
  input  wire logic [11:0] sampleIn,
  output logic      [11:0] filtered
);

  aic_pkg::aic_div_state_type state_q, state_d;
  logic [7:0]  tcSeen_q, tcSeen_d;
  logic [16:0] alpha_q, alpha_d;
  logic [16:0] quo_q, quo_d;
  logic [8:0]  rem_q, rem_d;
  logic [4:0]  bitCnt_q, bitCnt_d;
  logic [27:0] acc_q, acc_d;

  wire  [8:0]  divisor = {1'b0, tcSeen_q} + 9'h001;
  wire  [9:0]  shifted = {rem_q, aic_pkg::ALPHA_ONE[bitCnt_q]};
  wire         fits    = shifted >= {1'b0, divisor};
  wire  [9:0]  remNext = fits ? shifted - {1'b0, divisor} : shifted;

  // ----------------------------------------------------------------
  // coefficient: one over (steps + 1)
  // ----------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    tcSeen_d = tcSeen_q;
    alpha_d  = alpha_q;
    quo_d    = quo_q;
    rem_d    = rem_q;
    bitCnt_d = bitCnt_q;
    case (state_q)
      aic_pkg::DIV_IDLE: begin
        if (timeConst != tcSeen_q) begin
          tcSeen_d = timeConst;
          quo_d    = 17'h00000;
          rem_d    = 9'h000;
          bitCnt_d = 5'h10;
          state_d  = aic_pkg::DIV_RUN;
        end
      end
      aic_pkg::DIV_RUN: begin
        rem_d = remNext[8:0];
        quo_d = {quo_q[15:0], fits};
        if (bitCnt_q == 5'h00) begin
          state_d = aic_pkg::DIV_DONE;
        end else begin
          bitCnt_d = bitCnt_q - 5'h01;
        end
      end
      aic_pkg::DIV_DONE: begin
        alpha_d = quo_q;
        state_d = aic_pkg::DIV_IDLE;
      end
      default: begin
        state_d = aic_pkg::DIV_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // recursive update
  // ----------------------------------------------------------------
  wire signed [28:0] diff = $signed({1'b0, sampleIn, 16'h0000}) - $signed({1'b0, acc_q});
  wire signed [46:0] prod = diff * $signed({1'b0, alpha_q});
  wire signed [46:0] step = prod >>> aic_pkg::FRAC_W;

  always_comb begin
    acc_d = acc_q;
    if (tick) begin
      if (timeConst == 8'h00) begin
        acc_d = {sampleIn, 16'h0000};
      end else begin
        acc_d = acc_q + step[27:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q  <= aic_pkg::DIV_IDLE;
      tcSeen_q <= 8'h00;
      alpha_q  <= aic_pkg::ALPHA_ONE;
      quo_q    <= 17'h00000;
      rem_q    <= 9'h000;
      bitCnt_q <= 5'h00;
      acc_q    <= 28'h0000000;
    end else begin
      state_q  <= state_d;
      tcSeen_q <= tcSeen_d;
      alpha_q  <= alpha_d;
      quo_q    <= quo_d;
      rem_q    <= rem_d;
      bitCnt_q <= bitCnt_d;
      acc_q    <= acc_d;
    end
  end

  assign filtered = acc_q[27:16];

endmodule // aic_filter

// [tb/aic_top_assertions.sv]
// port checker for the analog input conditioning block
module aic_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  regAddr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  input wire logic [15:0] primaryOut,
  input wire logic [15:0] secondaryOut,
  input wire logic [15:0] gainScaleFactor,
  input wire logic        outStrobe,
  input wire logic [4:0]  secondaryRole,
  input wire logic        secondaryRoleActive
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data not zero outside read");
  out_read_a: assert property ($past(regRd) && $past(regAddr) == aic_pkg::REG_PRI_OUT
    |-> regRdData == $past(primaryOut)) else $error("primary read mismatch");
  strobe_pulse_a: assert property (outStrobe |=> !outStrobe [*8])
    else $error("strobe too long or too dense");
  out_update_a: assert property ($changed(primaryOut) || $changed(secondaryOut)
    |-> outStrobe) else $error("output changed without strobe");
  role_range_a: assert property (secondaryRole <= aic_pkg::FUNC_MAX)
    else $error("role code out of range");
  role_reserved_a: assert property (secondaryRoleActive ==
    (secondaryRole != aic_pkg::FUNC_RSV_A && secondaryRole != aic_pkg::FUNC_RSV_B))
    else $error("reserved role active flag wrong");
  gain_limit_a: assert property (gainScaleFactor <= aic_pkg::GAIN_MAX)
    else $error("effective gain above limit");
  gain_scale_factor_zero_a: assert property ((secondaryRole == aic_pkg::FUNC_FREQ_GAIN
    && $signed(secondaryOut) <= 0) [*2] |-> gainScaleFactor == 16'h0000)
    else $error("gain not zero with zero scale");
  eff_read_a: assert property ($past(regRd) && $past(regAddr) == aic_pkg::REG_EFF_GAIN
    |-> regRdData == $past(gainScaleFactor)) else $error("effective gain read mismatch");
endmodule // aic_checker

bind aic_top aic_checker u_chk (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData),
  .primaryOut(primaryOut), .secondaryOut(secondaryOut), .gainScaleFactor(gainScaleFactor),
  .outStrobe(outStrobe), .secondaryRole(secondaryRole),
  .secondaryRoleActive(secondaryRoleActive)
);

// [tb/aic_frontend_model.sv]
// sampled analog front end model feeding both converter inputs
module aic_frontend_model (
  input  wire logic        clk,
  input  wire logic [11:0] levelPri,
  input  wire logic [11:0] levelSec,
  input  wire logic        switchCurrent,
  output logic      [11:0] analogInPrimary,
  output logic      [11:0] analogInSecondary,
  output logic             inputKindSwitch
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // converter codes, one new code per clock
  // ----------------------------------------------------------------
  logic [11:0] pri_q = 12'h000;
  logic [11:0] sec_q = 12'h000;
  logic        sw_q  = 1'b0;
  always_ff @(posedge clk) begin
    pri_q <= levelPri;
    sec_q <= levelSec;
    sw_q  <= switchCurrent;
  end
  assign analogInPrimary   = pri_q;
  assign analogInSecondary = sec_q;
  assign inputKindSwitch   = sw_q;
endmodule // aic_frontend_model

// [tb/tb_top.sv]
// self-checking bench for the analog input conditioning block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst_n, regWr, regRd, swI, outStrobe, secondaryRoleActive, inputKindSwitch;
  logic [3:0]  regAddr;
  logic [11:0] lvlP, lvlS, analogInPrimary, analogInSecondary;
  logic [15:0] regWrData, rdv, regRdData, primaryOut, secondaryOut, gainScaleFactor;
  logic [4:0]  secondaryRole;
  int          failures = 0, testsRun = 0, seed, i, g, b, g2, b2, x, y, s;
  longint      e;
  logic [15:0] rstTab [12] = '{16'h0000, 16'h0000, 16'h03E8, 16'h0000, 16'h0000,
    16'h03E8, 16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h03E8, 16'h0000};

  always #25 clk = ~clk;

  aic_frontend_model fe (.clk(clk), .levelPri(lvlP), .levelSec(lvlS), .switchCurrent(swI),
    .analogInPrimary(analogInPrimary), .analogInSecondary(analogInSecondary),
    .inputKindSwitch(inputKindSwitch));
  aic_top #(.TICK_CYCLES(20)) dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .analogInPrimary(analogInPrimary), .analogInSecondary(analogInSecondary),
    .inputKindSwitch(inputKindSwitch), .primaryOut(primaryOut),
    .secondaryOut(secondaryOut), .gainScaleFactor(gainScaleFactor), .outStrobe(outStrobe),
    .secondaryRole(secondaryRole), .secondaryRoleActive(secondaryRoleActive));

  // ----------------------------------------------------------------
  // expectations, bus tasks, verdict
  // ----------------------------------------------------------------
  function automatic logic [15:0] mapv(int gn, int bs, int f);
    mapv = 16'(bs + ((gn - bs) * f >>> 12));
  endfunction
  // live zero removes a fifth of full scale
  function automatic int lz(int v);
    int a;
    a = (v > 819) ? v - 819 : 0;
    lz = (a + (a >> 2) > 4095) ? 4095 : a + (a >> 2);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdData;
  endtask
  task automatic strobes(int n);
    int k;
    repeat (n) begin
      k = 0;
      @(posedge clk);
      while (outStrobe !== 1'b1 && k < 60) begin
        @(posedge clk);
        k++;
      end
      if (k == 60) failures++;
    end
    #1;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end

  initial begin
    seed = 32'h6071308e;
    {rst_n, regWr, regRd, swI, regAddr, regWrData, lvlP, lvlS} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 12; i++) begin
      rd(4'(i));
      chk(rdv, rstTab[i]);
    end
    wr(4'hC, 16'hFFFF);
    rd(4'hC);
    chk(rdv, 16'h0000);
    wr(4'h2, 16'hFFFF);
    rd(4'h2);
    chk(rdv, aic_pkg::GAIN_MAX);
    wr(4'h3, 16'h7FFF);
    rd(4'h3);
    chk(rdv, aic_pkg::BIAS_MAX);
    wr(4'h3, 16'h8000);
    rd(4'h3);
    chk(rdv, aic_pkg::BIAS_MIN);
    wr(4'h4, 16'hFFFF);
    rd(4'h4);
    chk(rdv, 16'h00C8);
    wr(4'h0, 16'h0105);
    wr(4'h0, 16'h1200);
    rd(4'h0);
    chk(rdv, 16'h0100);
    for (i = 0; i < 18; i++) begin
      wr(4'h0, 16'(i << 8));
      #1;
      chk({11'h000, secondaryRole}, 16'(i));
      chk({15'h0000, secondaryRoleActive}, 16'(i != 15 && i != 17));
    end
    swI <= 1'b1;
    repeat (4) @(posedge clk);
    rd(4'h7);
    chk(rdv, 16'h0001);
    wr(4'h4, 16'h0000);
    for (i = 0; i < 8; i++) begin
      g = (i == 0) ? 10000 : {$random(seed)} % 10001;
      b = (i == 0) ? -1000 : int'({$random(seed)} % 2001) - 1000;
      g2 = {$random(seed)} % 10001;
      b2 = int'({$random(seed)} % 2001) - 1000;
      x = (i == 0) ? 4095 : (i == 1) ? 0 : {$random(seed)} % 4096;
      y = (i < 2) ? x : {$random(seed)} % 4096;
      wr(4'h2, 16'(g));
      wr(4'h3, 16'(b));
      wr(4'h5, 16'(g2));
      wr(4'h6, 16'(b2));
      wr(4'h0, 16'(i % 2));
      lvlP <= 12'(x);
      lvlS <= 12'(y);
      strobes(2);
      chk(primaryOut, mapv(g, b, x));
      chk(secondaryOut, mapv(g2, b2, (i % 2) ? lz(y) : y));
    end
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'd1000);
    wr(4'h3, 16'h0000);
    wr(4'h5, 16'd1000);
    wr(4'h6, 16'h0000);
    lvlP <= 12'h000;
    lvlS <= 12'h000;
    wr(4'h1, 16'h000A);
    strobes(3);
    lvlP <= 12'hFFF;
    lvlS <= 12'hFFF;
    strobes(1);
    chk(secondaryOut, mapv(1000, 0, 4095));
    chk({15'h0000, primaryOut < 16'd630}, 16'h0001);
    strobes(10);
    chk({15'h0000, primaryOut >= 16'd630}, 16'h0001);
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0100);
    for (i = 0; i < 3; i++) begin
      g = (i == 0) ? 10000 : (i == 1) ? {$random(seed)} % 10001 : 1000;
      y = (i == 0) ? 4095 : (i == 1) ? {$random(seed)} % 4096 : 0;
      wr(4'h2, 16'(g));
      lvlS <= 12'(y);
      strobes(2);
      repeat (2) @(posedge clk);
      #1;
      s = int'(mapv(1000, 0, y));
      e = (longint'(g) * s * 1049) >> 20;
      if (e > 10000) e = 10000;
      chk(gainScaleFactor, 16'(e));
      rd(4'hA);
      chk(rdv, 16'(e));
    end
    wr(4'h0, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk(gainScaleFactor, 16'(g));
    summarize();
  end
endmodule // tb_top
